// ### rtl/ciet_pkg.sv
// Purpose: shared constants for the interrupt entry sequencer
// Assumes: one core clock, cycle counts fixed by the pipeline
// Notes: state codes follow a Gray path idle-arb-nop-call-idle
package ciet_pkg;
  localparam int unsigned NUM_SRC = 8;           // interrupt sources
  localparam int unsigned IDX_W = 3;             // source index width
  localparam logic [2:0] ARB_CYCLES = 3'h1;      // arbitration cycle
  localparam logic [2:0] NOP_CYCLES = 3'h3;      // forced nop cycles
  localparam logic [2:0] CALL_SHORT = 3'h4;      // short vector call
  localparam logic [2:0] CALL_LONG = 3'h5;       // long vector call
  localparam logic [2:0] REARB_CALL = 3'h3;      // call cycles before rearb
  localparam logic [1:0] BCC_SHIELD = 2'h2;      // guarded instructions
  localparam logic [3:0] MAX_INSTR_CYCLES = 4'h8; // longest instruction
  localparam logic [2:0] CNT_RESET = 3'h0;       // counter reset value

  typedef enum logic [1:0] {
    CIET_IDLE = 2'b00, // normal execution
    CIET_ARB = 2'b01,  // accepted, arbitration cycle
    CIET_NOP = 2'b11,  // forced nop cycles
    CIET_CALL = 2'b10  // vector subroutine call
  } ciet_state_t;
endpackage

// ### rtl/ciet_arbiter.sv
// Purpose: arbitration stage feeding the core request stage
// Assumes: sources hold their request until acknowledged
// Notes: highest source index wins
module ciet_arbiter
  import ciet_pkg::*;
(
  input wire logic core_clk, // core clock
  input wire logic resetn, // async reset, active low
  input wire logic [NUM_SRC-1:0] irqPend, // pending requests
  input wire logic [NUM_SRC-1:0] irqEnable, // per-source enables
  input wire logic sampleEn, // arbitration allowed this cycle
  output logic reqValid, // request stage holds a winner
  output logic [IDX_W-1:0] reqIndex // winning source index
);
  // pick the highest enabled pending source
  function automatic logic [IDX_W-1:0] pickTop(
    input logic [NUM_SRC-1:0] vec);
    logic [IDX_W-1:0] idx;
    idx = '0;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (vec[i]) begin
        idx = IDX_W'(i);
      end
    end
    return idx;
  endfunction

  logic [NUM_SRC-1:0] live; // enabled pending sources
  logic anyLive; // something to arbitrate
  logic reqValid_r; // request stage valid
  logic [IDX_W-1:0] reqIndex_r; // request stage index

  assign live = irqPend & irqEnable;
  assign anyLive = |live;
  assign reqValid = reqValid_r;
  assign reqIndex = reqIndex_r;

  // winner moves to the request stage one cycle after sampling
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      reqValid_r <= 1'b0;
      reqIndex_r <= '0;
    end else begin
      reqValid_r <= sampleEn & anyLive;
      reqIndex_r <= pickTop(live);
    end
  end

  AST_REQ_STAGE: assert property (@(posedge core_clk) disable iff (!resetn)
    sampleEn && anyLive |=> reqValid)
    else $error("arbitration winner did not reach request stage");
endmodule

// ### rtl/ciet_entry.sv
// Purpose: sequences interrupt entry into the core pipeline
// Assumes: core flags instruction boundaries and wait states
// Notes: stack and fetch wait states stretch only the call phase
module ciet_entry
  import ciet_pkg::*;
(
  input wire logic core_clk, // core clock, 10 MHz
  input wire logic resetn, // async reset, active low
  input wire logic [NUM_SRC-1:0] irqPend, // source requests
  input wire logic [NUM_SRC-1:0] irqEnable, // source enables
  input wire logic instrBoundary, // current instruction completes
  input wire logic condBranchFalse, // short branch not taken
  input wire logic repActive, // repeat loop in progress
  input wire logic stopState, // core in stop state
  input wire logic waitState, // core in low-power wait
  input wire logic pushWait, // stack write wait state
  input wire logic fetchWait, // program fetch wait state
  input wire logic callLong, // vector call takes five cycles
  output logic irqAck, // pulse, acknowledges winning source
  output logic [IDX_W-1:0] vectorIndex, // source being serviced
  output logic forceNop, // forced nop into pipeline
  output logic vectorCall, // vector call executing
  output logic pushProgramCounter, // push program_counter
  output logic pushStatusRegister, // push status_register
  output logic handlerStart, // pulse, first handler instr next
  output logic arbEnable, // arbitration permitted
  output logic fetchEnable, // instruction fetch allowed
  output logic wakeFromWait // leave the wait state
);
  ciet_state_t state_r; // sequencer state
  ciet_state_t state_nxt; // next state
  logic [2:0] cnt_r; // cycle counter within a phase
  logic [2:0] cnt_nxt; // next counter value
  logic [2:0] callLen_r; // latched call length
  logic [1:0] shield_r; // instructions still guarded
  logic [1:0] shield_nxt; // next guard count
  logic [IDX_W-1:0] vecIdx_r; // serviced source
  logic reqValid; // request stage valid
  logic [IDX_W-1:0] reqIndex; // request stage index
  logic inIdle; // no entry in progress
  logic inArb; // arbitration cycle
  logic inNop; // forced nop phase
  logic inCall; // vector call phase
  logic stall; // wait state freezes the call
  logic boundaryOk; // a legal point to interrupt
  logic accept; // request taken this cycle
  logic nopDone; // last nop cycle
  logic callDone; // last call cycle completes
  logic rearbOk; // call far enough along

  // the arbiter is the only place requests are sampled
  ciet_arbiter u_arb (
    .core_clk(core_clk),
    .resetn(resetn),
    .irqPend(irqPend),
    .irqEnable(irqEnable),
    .sampleEn(arbEnable),
    .reqValid(reqValid),
    .reqIndex(reqIndex)
  );

  // state decodes
  assign inIdle = (state_r == CIET_IDLE);
  assign inArb = (state_r == CIET_ARB);
  assign inNop = (state_r == CIET_NOP);
  assign inCall = (state_r == CIET_CALL);

  // wait states on pushes or vector fetches hold the call
  assign stall = inCall & (pushWait | fetchWait);

  // the instruction in flight must finish first, however long
  // a boundary inside a repeat loop or in stop is not usable
  // the false branch's own boundary is the first shielded one
  assign boundaryOk = (instrBoundary | waitState)
                    & ~repActive
                    & ~stopState
                    & ~condBranchFalse
                    & (shield_r == 2'h0);

  // the request simply stays in the arbiter until accepted
  assign accept = inIdle & reqValid & boundaryOk;

  assign nopDone = inNop & (cnt_r == NOP_CYCLES - 3'h1);
  assign callDone = inCall & ~stall
                  & (cnt_r == callLen_r - 3'h1);
  // counting unstalled cycles only: stalls push re-enable back
  assign rearbOk = inCall & (cnt_r >= REARB_CALL);

  // arbitration runs in idle and again late in the call
  assign arbEnable = (inIdle | rearbOk) & ~stopState;

  assign irqAck = accept;
  assign vectorIndex = vecIdx_r;
  assign forceNop = inNop;
  assign vectorCall = inCall;
  // both pushes happen in the first two unstalled call cycles
  assign pushProgramCounter = inCall & (cnt_r == 3'h0);
  assign pushStatusRegister = inCall & (cnt_r == 3'h1);
  assign handlerStart = callDone;
  assign fetchEnable = ~repActive;
  assign wakeFromWait = waitState & reqValid & ~stopState;

  // next-state logic for the entry sequence
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    unique case (state_r)
      CIET_IDLE: begin
        cnt_nxt = CNT_RESET;
        if (accept) begin
          state_nxt = CIET_ARB;
        end
      end
      CIET_ARB: begin
        // single arbitration cycle, nops follow
        state_nxt = CIET_NOP;
        cnt_nxt = CNT_RESET;
      end
      CIET_NOP: begin
        if (nopDone) begin
          state_nxt = CIET_CALL;
          cnt_nxt = CNT_RESET;
        end else begin
          cnt_nxt = cnt_r + 3'h1;
        end
      end
      CIET_CALL: begin
        if (callDone) begin
          state_nxt = CIET_IDLE;
          cnt_nxt = CNT_RESET;
        end else if (!stall) begin
          cnt_nxt = cnt_r + 3'h1;
        end
      end
    endcase
  end

  // guard count for instructions after a false short branch
  always_comb begin
    shield_nxt = shield_r;
    if (instrBoundary && condBranchFalse) begin
      // branch boundary refused directly, one more stays guarded
      shield_nxt = BCC_SHIELD - 2'h1;
    end else if (instrBoundary && shield_r != 2'h0) begin
      shield_nxt = shield_r - 2'h1;
    end
  end

  // sequencer registers
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= CIET_IDLE;
      cnt_r <= CNT_RESET;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // call length and source latched at acceptance
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      callLen_r <= CALL_SHORT;
      vecIdx_r <= '0;
    end else if (accept) begin
      callLen_r <= callLong ? CALL_LONG : CALL_SHORT;
      vecIdx_r <= reqIndex;
    end
  end

  // branch guard register
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      shield_r <= 2'h0;
    end else begin
      shield_r <= shield_nxt;
    end
  end

  // helper: unstalled call cycles, only read by assertions
  logic [2:0] callRun_r; // cycles of call progress
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      callRun_r <= 3'h0;
    end else if (!inCall) begin
      callRun_r <= 3'h0;
    end else if (!stall) begin
      callRun_r <= callRun_r + 3'h1;
    end
  end

  sequence seqNops;
    forceNop [*3];
  endsequence

  sequence seqEntry;
    inArb ##1 seqNops ##1 inCall;
  endsequence

  AST_ACCEPT_BOUNDARY: assert property (
    @(posedge core_clk) disable iff (!resetn)
    irqAck |-> (instrBoundary || waitState) && inIdle)
    else $error("interrupt accepted off an instruction boundary");

  AST_ENTRY_FOUR: assert property (
    @(posedge core_clk) disable iff (!resetn)
    irqAck |=> seqEntry)
    else $error("entry was not arb plus three nops");

  AST_CALL_LEN: assert property (
    @(posedge core_clk) disable iff (!resetn)
    handlerStart |-> (callRun_r == 3'h3 || callRun_r == 3'h4))
    else $error("vector call length not four or five");

  AST_PUSH_WAIT: assert property (
    @(posedge core_clk) disable iff (!resetn)
    vectorCall && pushWait |-> !handlerStart ##1 vectorCall)
    else $error("push wait state did not stretch the call");

  AST_FETCH_WAIT: assert property (
    @(posedge core_clk) disable iff (!resetn)
    vectorCall && fetchWait |=> $stable(cnt_r))
    else $error("fetch wait state did not hold the call");

  AST_REARB: assert property (
    @(posedge core_clk) disable iff (!resetn)
    vectorCall && arbEnable |-> callRun_r >= 3'h3)
    else $error("arbitration resumed before three call cycles");

  AST_NO_ARB_ENTRY: assert property (
    @(posedge core_clk) disable iff (!resetn)
    irqAck |=> !arbEnable [*5])
    else $error("arbitration enabled during entry");

  AST_BCC_GUARD: assert property (
    @(posedge core_clk) disable iff (!resetn)
    (instrBoundary && condBranchFalse) || shield_r != 2'h0 |-> !irqAck)
    else $error("interrupt accepted inside guarded branch shadow");

  AST_BCC_ARM: assert property (
    @(posedge core_clk) disable iff (!resetn)
    instrBoundary && condBranchFalse |=> shield_r == BCC_SHIELD - 2'h1)
    else $error("branch guard was not armed");

  AST_STOP: assert property (
    @(posedge core_clk) disable iff (!resetn)
    stopState |-> !irqAck && !arbEnable)
    else $error("request recognised in stop state");

  AST_WAKE: assert property (
    @(posedge core_clk) disable iff (!resetn)
    waitState && !stopState && $past(arbEnable)
    && $past(|(irqPend & irqEnable)) |-> wakeFromWait)
    else $error("enabled request did not wake the core");

  AST_REPEAT: assert property (
    @(posedge core_clk) disable iff (!resetn)
    repActive |-> !irqAck && !fetchEnable)
    else $error("repeat loop interrupted or fetch active");

  AST_PENDING: assert property (
    @(posedge core_clk) disable iff (!resetn)
    inIdle && reqValid && !irqAck && !stopState
    && ((irqPend & irqEnable) != '0) |=> reqValid)
    else $error("rejected request was dropped");

  // status push must follow the counter push once it is free
  AST_PUSH_ORDER: assert property (
    @(posedge core_clk) disable iff (!resetn)
    pushProgramCounter && !stall |=> pushStatusRegister)
    else $error("status push did not follow counter push");

  AST_HANDLER_IDLE: assert property (
    @(posedge core_clk) disable iff (!resetn)
    handlerStart |=> inIdle && !vectorCall)
    else $error("call did not end after handler start");

  // arbitration must really come back, not only stay off early
  AST_REARB_ON: assert property (
    @(posedge core_clk) disable iff (!resetn)
    vectorCall && callRun_r >= REARB_CALL && !stopState |-> arbEnable)
    else $error("arbitration not resumed late in the call");

  AST_FETCH_ON: assert property (
    @(posedge core_clk) disable iff (!resetn)
    !repActive |-> fetchEnable)
    else $error("fetch held off outside a repeat loop");

  AST_REQ_LATCH: assert property (
    @(posedge core_clk) disable iff (!resetn)
    irqAck |=> vectorIndex == $past(reqIndex))
    else $error("serviced index differs from request stage");
endmodule

// ### testbench/ciet_src_model.sv
// Purpose: interrupt sources that hold a request until it is taken
// Assumes: the bench pulses fire for one cycle per new request
// Notes: on ack the highest enabled pending source is cleared
module ciet_src_model (
  input wire logic core_clk, // core clock
  input wire logic resetn, // async reset, active low
  input wire logic [7:0] fire, // new request pulses
  input wire logic [7:0] irqEnable, // enables, to find the winner
  input wire logic irqAck, // ack from the entry unit
  output logic [7:0] irqPend // held requests
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] winMask; // highest enabled pending source

  // same priority as the arbiter, so the right source drops
  always_comb begin
    winMask = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (irqPend[i] && irqEnable[i]) winMask = 8'h01 << i;
    end
  end

  // a refused request simply stays up until it is acknowledged
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) irqPend <= 8'h00;
    else irqPend <= (irqPend | fire) & ~(irqAck ? winMask : 8'h00);
  end
endmodule

// ### testbench/tb_top.sv
// Purpose: self-checking bench for the interrupt entry sequencer
// Assumes: inputs change at the falling edge, checks 10 ns later
// Notes: ctl bits are stop wait rep brfalse fwait pwait boundary
module tb_top
  import ciet_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk, resetn, instrBoundary, condBranchFalse, repActive;
  logic stopState, waitState, pushWait, fetchWait, callLong;
  logic [7:0] irqPend, irqEnable, fire; // requests and enables
  logic irqAck, forceNop, vectorCall, pushProgramCounter;
  logic pushStatusRegister, handlerStart, arbEnable, fetchEnable;
  logic wakeFromWait;
  logic [IDX_W-1:0] vectorIndex; // serviced source
  int err_total, check_count, n, nops;
  // rows: source, long call, stall cycles, fetch stall, latency
  int rowTab [8][5] = '{'{0, 0, 0, 0, 8}, '{1, 1, 0, 0, 9},
    '{2, 0, 1, 0, 9}, '{3, 1, 1, 1, 10}, '{4, 0, 2, 1, 10},
    '{5, 1, 2, 0, 11}, '{6, 0, 0, 1, 8}, '{7, 1, 1, 0, 10}};

  ciet_entry i_dut (.core_clk(core_clk), .resetn(resetn),
    .irqPend(irqPend), .irqEnable(irqEnable),
    .instrBoundary(instrBoundary), .condBranchFalse(condBranchFalse),
    .repActive(repActive), .stopState(stopState),
    .waitState(waitState), .pushWait(pushWait), .fetchWait(fetchWait),
    .callLong(callLong), .irqAck(irqAck), .vectorIndex(vectorIndex),
    .forceNop(forceNop), .vectorCall(vectorCall),
    .pushProgramCounter(pushProgramCounter),
    .pushStatusRegister(pushStatusRegister),
    .handlerStart(handlerStart), .arbEnable(arbEnable),
    .fetchEnable(fetchEnable), .wakeFromWait(wakeFromWait));
  ciet_src_model i_src (.core_clk(core_clk), .resetn(resetn),
    .fire(fire), .irqEnable(irqEnable), .irqAck(irqAck),
    .irqPend(irqPend));

  // free running 10 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic close_out();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: flag %b want %b", $time, got, exp);
    end
  endtask

  task automatic chk_idx(input logic [IDX_W-1:0] got, input int exp);
    check_count++;
    if (got !== IDX_W'(exp)) begin
      err_total++;
      $display("mismatch at %0t: index %0d want %0d", $time, got, exp);
    end
  endtask

  // one cycle: drive at the falling edge, settle before checking
  task automatic step(input logic [6:0] c, input logic [7:0] f);
    @(negedge core_clk);
    {stopState, waitState, repActive, condBranchFalse} = c[6:3];
    {fetchWait, pushWait, instrBoundary} = c[2:0];
    fire = f;
    #10;
  endtask

  // run an accepted entry out, bounded so a stuck call cannot hang
  task automatic drain();
    for (int k = 0; handlerStart !== 1'b1; k++) begin
      step(7'h00, 8'h00);
      if (k > 30) begin
        err_total++;
        $display("mismatch at %0t: handler never started", $time);
        close_out();
      end
    end
  endtask

  // one ordinary entry: ack, nops, call with stalls, handler start
  task automatic run_row(input int r);
    logic s;
    @(negedge core_clk);
    callLong = rowTab[r][1][0];
    fire = 8'h01 << rowTab[r][0];
    #10;
    step(7'h00, 8'h00);
    step(7'h01, 8'h00);
    chk_bit(irqAck, 1'b1);
    nops = 0;
    for (n = 1; n <= 20; n++) begin
      s = n >= 6 && n < 6 + rowTab[r][2];
      step({4'h0, s && rowTab[r][3] != 0, s && rowTab[r][3] == 0, 1'b0},
        8'h00);
      nops += int'(forceNop === 1'b1);
      if (n == 5) chk_bit(pushProgramCounter & vectorCall, 1'b1);
      if (n == 6) chk_bit(pushStatusRegister, 1'b1);
      if (n == 7 + rowTab[r][2]) chk_bit(arbEnable, 1'b0);
      if (n == 8 + rowTab[r][2]) chk_bit(arbEnable, 1'b1);
      if (handlerStart === 1'b1) break;
    end
    chk_bit(n == rowTab[r][4], 1'b1);
    chk_bit(nops == 3, 1'b1);
    chk_idx(vectorIndex, rowTab[r][0]);
  endtask

  initial begin
    err_total = 0;
    check_count = 0;
    resetn = 1'b0;
    irqEnable = 8'hFF;
    callLong = 1'b0;
    {stopState, waitState, repActive, condBranchFalse} = 4'h0;
    {fetchWait, pushWait, instrBoundary} = 3'h0;
    fire = 8'h00;
    repeat (8) @(posedge core_clk);
    @(negedge core_clk);
    chk_bit(irqAck, 1'b0);
    chk_bit(arbEnable, 1'b1);
    chk_idx(vectorIndex, 0);
    resetn = 1'b1;
    for (int r = 0; r < 8; r++) run_row(r);
    // a false short branch and the instruction after it are shielded
    step(7'h00, 8'h10);
    step(7'h00, 8'h00);
    for (int k = 0; k < 3; k++) begin
      step((k == 0) ? 7'h09 : 7'h01, 8'h00);
      chk_bit(irqAck, k == 2);
    end
    drain();
    // stop state ignores requests, which then stay pending
    step(7'h40, 8'h20);
    step(7'h40, 8'h00);
    for (int k = 0; k < 3; k++) begin
      step(7'h41, 8'h00);
      chk_bit(irqAck | arbEnable, 1'b0);
    end
    step(7'h00, 8'h00);
    step(7'h01, 8'h00);
    chk_bit(irqAck, 1'b1);
    drain();
    // wait state: a disabled source must not wake the core
    @(negedge core_clk);
    irqEnable = 8'h00;
    step(7'h20, 8'h02);
    step(7'h20, 8'h00);
    step(7'h20, 8'h00);
    chk_bit(wakeFromWait, 1'b0);
    @(negedge core_clk);
    irqEnable = 8'hFF;
    step(7'h20, 8'h00);
    chk_bit(wakeFromWait & irqAck, 1'b1);
    drain();
    // repeat loop: no fetch, no service until the loop ends
    step(7'h10, 8'h04);
    chk_bit(fetchEnable, 1'b0);
    step(7'h10, 8'h00);
    for (int k = 0; k < 2; k++) begin
      step(7'h11, 8'h00);
      chk_bit(irqAck, 1'b0);
    end
    step(7'h01, 8'h00);
    chk_bit(irqAck & fetchEnable, 1'b1);
    drain();
    // the longest instruction holds acceptance until its boundary
    step(7'h00, 8'h08);
    for (int k = 0; k < int'(MAX_INSTR_CYCLES); k++) begin
      step({6'h00, k == int'(MAX_INSTR_CYCLES) - 1}, 8'h00);
      chk_bit(irqAck, k == int'(MAX_INSTR_CYCLES) - 1);
    end
    step(7'h00, 8'h00);
    step(7'h00, 8'h00);
    chk_bit(forceNop, 1'b1);
    // reset in mid-entry drops the sequence back to idle
    @(negedge core_clk);
    resetn = 1'b0;
    #10;
    chk_bit(forceNop | vectorCall | irqAck, 1'b0);
    chk_bit(arbEnable, 1'b1);
    chk_idx(vectorIndex, 0);
    @(negedge core_clk);
    resetn = 1'b1;
    step(7'h01, 8'h00);
    chk_bit(irqAck | ~arbEnable, 1'b0);
    close_out();
  end
endmodule
